// ### dv/ptb_addon_model.sv
// partner: add-on logic serving the data holding register
`timescale 1ns/10ps
`default_nettype none
module ptb_addon_model
  import ptb_pkg::*;
(
  // clock and device status
  input  wire logic        clk_sys_i,
  input  wire logic        attn_n_i,
  input  wire logic        is_wr_i,
  input  wire logic [3:0]  pend_i,
  input  wire logic [31:0] dq_i,
  // scenario controls
  input  wire logic        narrow_i,
  input  wire logic [7:0]  slow_i,
  // register port
  output logic             sel_n_o,
  output logic [6:2]       addr_o,
  output logic [3:0]       be_n_o,
  output logic             wr_n_o,
  output logic             rd_n_o,
  output logic [31:0]      dq_o,
  output logic             rdy_n_o,
  // word reassembled from reads
  output logic [31:0]      got_o,
  output logic             done_o
);
  logic [31:0] word = 32'h0000_0000;
  logic [7:0]  lag  = 8'h00;
  int          k    = -1;
  logic        go;
  // holding register at its fixed offset
  assign addr_o = PTB_OFS_DATA_HOLD[6:2];
  task automatic drive(input logic w, input logic r, input logic [3:0] b, input logic y);
    wr_n_o  = w;
    rd_n_o  = r;
    sel_n_o = w & r;
    be_n_o  = b;
    rdy_n_o = y;
  endtask
  initial begin
    drive(1'b1, 1'b1, 4'hF, 1'b1);
    dq_o   = 32'h0000_0000;
    got_o  = 32'h0000_0000;
    done_o = 1'b0;
  end
  always begin
    @(posedge clk_sys_i);
    #1;
    if (k >= 0 && narrow_i) got_o[8*k +: 8] = dq_i[7:0];
    else if (k >= 0) got_o = dq_i;
    k = -1;
    // nothing while attention high; after each ready, quiet for one clock or slow_i clocks, whichever is more
    go = !attn_n_i && lag >= slow_i && rdy_n_o;
    lag = (attn_n_i || go) ? 8'h00 : lag + 8'h01;
    done_o = go && is_wr_i && pend_i == 4'hF;
    if (go && !is_wr_i) begin
      // all pending bytes written with ready
      drive(1'b0, 1'b1, pend_i, 1'b0);
      dq_o = word;
      word = word + 32'h0000_0001;
    end else if (go && pend_i != 4'hF) begin
      // narrow region read one byte at a time
      k = 0;
      while (pend_i[k]) k++;
      drive(1'b1, 1'b0, narrow_i ? ~(4'h1 << k) : pend_i, 1'b1);
      dq_o = ~dq_o;
    end else begin
      // ready once every byte is read; released bus keeps moving
      drive(1'b1, 1'b1, 4'hF, !go);
      dq_o = ~dq_o;
    end
  end
endmodule
`default_nettype wire

// ### dv/ptb_passthru_chk.sv
// checker: timing relations at the pass-through ports
`timescale 1ns/10ps
`default_nettype none
module ptb_passthru_chk
  import ptb_pkg::*;
(
  // clock, reset, pci side
  input wire logic       clk_sys_i,
  input wire logic       nrst_i,
  input wire logic       pci_frame_hit_i,
  input wire logic       pci_trdy_n_o,
  input wire logic       pci_stop_n_o,
  input wire logic       pci_busy_o,
  // add-on side and status
  input wire logic       local_select_n_i,
  input wire logic       local_wr_n_i,
  input wire logic       local_rd_n_i,
  input wire logic [6:2] local_addr_i,
  input wire logic [3:0] local_byte_en_n_i,
  input wire logic       local_xfer_ready_n_i,
  input wire logic       local_dq_oe_o,
  input wire logic       passthru_attention_n_o,
  input wire logic       pci_burst_flag_n_o,
  input wire logic [3:0] pending_byte_en_n_o,
  input wire logic [1:0] region_index_o,
  input wire logic       access_is_write_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  logic [4:0] wait_cnt;
  wire        hit_data = !local_select_n_i && local_addr_i == PTB_OFS_DATA_HOLD[6:2];
  // edges without ready while attention low; saturates so a stuck add-on never wraps
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i || passthru_attention_n_o || !local_xfer_ready_n_i) begin
      wait_cnt <= 5'h00;
    end else if (wait_cnt != 5'h1F) begin
      wait_cnt <= wait_cnt + 5'h01;
    end
  end
  frame_attn_a: assert property (pci_frame_hit_i && !pci_busy_o && passthru_attention_n_o |=> !passthru_attention_n_o)
    else $error("no attention after frame hit");
  ready_trdy_a: assert property (!passthru_attention_n_o && !local_xfer_ready_n_i && pci_stop_n_o && !access_is_write_o
    |=> !pci_trdy_n_o)
    else $error("trdy late after ready");
  trdy_cause_a: assert property (!pci_trdy_n_o && !access_is_write_o |-> !$past(local_xfer_ready_n_i))
    else $error("trdy without ready");
  end_gap_a: assert property ($rose(passthru_attention_n_o) && pci_burst_flag_n_o |=> passthru_attention_n_o)
    else $error("attention back without idle clock");
  timeout_stop_a: assert property (wait_cnt >= 5'd17 && !access_is_write_o |-> !pci_stop_n_o)
    else $error("no stop after first phase timeout");
  early_stop_a: assert property ($fell(pci_stop_n_o) |-> $past(wait_cnt) >= 5'd6)
    else $error("stop before phase limit");
  retry_burst_a: assert property ($fell(pci_stop_n_o) |-> ##[0:1] pci_burst_flag_n_o)
    else $error("burst flag kept after retry");
  status_hold_a: assert property (!passthru_attention_n_o && !$past(passthru_attention_n_o)
    |-> $stable(region_index_o) && $stable(access_is_write_o))
    else $error("status moved under attention");
  pend_clear_a: assert property (!passthru_attention_n_o && hit_data && !(local_rd_n_i && local_wr_n_i) && local_xfer_ready_n_i
    |=> pending_byte_en_n_o == ($past(pending_byte_en_n_o) | ~$past(local_byte_en_n_i)))
    else $error("pending enables not cleared");
  read_drive_a: assert property (hit_data && !local_rd_n_i |=> local_dq_oe_o)
    else $error("read data not driven");
  cover property (!pci_trdy_n_o);
  cover property ($fell(pci_stop_n_o));
  cover property (hit_data && !local_rd_n_i);
endmodule
bind ptb_passthru ptb_passthru_chk u_ptb_passthru_chk (.*);
`default_nettype wire

// ### dv/ptb_passthru_test.sv
// testbench: scripted initiator against the block and the add-on model
`timescale 1ns/10ps
`default_nettype none
module ptb_passthru_test;
  import ptb_pkg::*;
  logic        clk_sys_i, nrst_i, hit, irdy_n, last, wr_valid, narrow, saw_stop, wr_ready, trdy_n, stop_n;
  logic        busy, oe, attn_n, burst_n, is_wr, done, sel_n, wr_n, rd_n, rdy_n;
  ptb_req_s    req;
  logic [31:0] wr_data, rd_data, dq_to, dq_from, got, wq[$];
  logic [6:2]  addr;
  logic [3:0]  be_n, pend;
  logic [1:0]  rgn_o;
  logic [7:0]  slow;
  int          seed, n_fail, checked, n_done, n_push, n_ph, exp_word, i;
  ptb_passthru u_ptb_passthru (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .pci_frame_hit_i(hit), .pci_req_i(req),
    .pci_irdy_n_i(irdy_n), .pci_last_i(last), .pci_wr_valid_i(wr_valid), .pci_wr_data_i(wr_data),
    .pci_wr_ready_o(wr_ready), .pci_trdy_n_o(trdy_n), .pci_stop_n_o(stop_n), .pci_rd_data_o(rd_data),
    .pci_busy_o(busy), .region_width_i({PTB_W32, PTB_W16, PTB_W32, PTB_W8}), .local_select_n_i(sel_n),
    .local_addr_i(addr), .local_addr_bit1_i(1'b0), .local_byte_en_n_i(be_n), .local_wr_n_i(wr_n),
    .local_rd_n_i(rd_n), .local_dq_i(dq_to), .local_dq_o(dq_from), .local_dq_oe_o(oe),
    .address_strobe_n_i(1'b1), .local_xfer_ready_n_i(rdy_n), .passthru_attention_n_o(attn_n),
    .pci_burst_flag_n_o(burst_n), .pending_byte_en_n_o(pend), .region_index_o(rgn_o), .access_is_write_o(is_wr));
  ptb_addon_model u_ptb_addon_model (.clk_sys_i(clk_sys_i), .attn_n_i(attn_n), .is_wr_i(is_wr), .pend_i(pend),
    .dq_i(dq_from), .narrow_i(narrow), .slow_i(slow), .sel_n_o(sel_n), .addr_o(addr), .be_n_o(be_n),
    .wr_n_o(wr_n), .rd_n_o(rd_n), .dq_o(dq_to), .rdy_n_o(rdy_n), .got_o(got), .done_o(done));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic complete_run();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_up();
    n_fail++;
    complete_run();
  endtask
  task automatic start(input logic [1:0] rgn, input logic wr, input int n, input logic [7:0] s);
    {n_done, n_push, n_ph} = {32'd0, 32'd0, n};
    saw_stop = 1'b0;
    slow = s;
    narrow = (rgn == 2'd0);
    req = '{rgn, wr, 4'h0, 32'($random(seed))};
    hit = 1'b1;
    @(posedge clk_sys_i);
    #1;
    hit = 1'b0;
    compare("region", {30'h0, rgn}, {30'h0, rgn_o});
  endtask
  task automatic wait_for(input int phases);
    for (i = 0; i < 300; i++) begin
      if (phases > 0 ? n_done >= phases : attn_n === 1'b1 && busy === 1'b0) break;
      @(posedge clk_sys_i);
      #1;
    end
    if (i == 300) give_up();
  endtask
  task automatic push(input logic [31:0] v);
    wr_valid = 1'b1;
    wr_data = v;
    wq.push_back(v);
    i = 0;
    do begin
      @(posedge clk_sys_i);
      i++;
    end while (wr_ready !== 1'b1 && i < 50);
    #1;
    if (i == 50) give_up();
  endtask
  always @(posedge clk_sys_i) begin
    if (rdy_n === 1'b0 && attn_n === 1'b0) n_done++;
    if (wr_valid && wr_ready === 1'b1) n_push++;
    if (stop_n === 1'b0) saw_stop = 1'b1;
    if (trdy_n === 1'b0 && !req.access_is_write && !saw_stop) begin
      compare("read data", exp_word, rd_data);
      exp_word++;
    end
    if (done === 1'b1) compare("drained word", wq.pop_front(), got);
    #1;
    last = ((req.access_is_write ? n_push : n_done) >= n_ph - 1);
  end
  initial begin
    seed = 96;
    {n_fail, checked, exp_word} = '0;
    {nrst_i, hit, irdy_n, wr_valid, saw_stop} = '0;
    wr_data = 32'h0000_0000;
    req = '0;
    repeat (5) @(posedge clk_sys_i);
    #1;
    nrst_i = 1'b1;
    // burst read with an initiator pause after two phases
    start(2'd1, 1'b0, 4, 8'd0);
    wait_for(2);
    irdy_n = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    compare("attention in wait", 32'h1, {31'h0, attn_n});
    irdy_n = 1'b0;
    wait_for(0);
    compare("trdy count", 32'h4, 32'(exp_word));
    // narrow write: two buffered words drained byte by byte, slowly
    // attention comes before the first word lands, so the add-on waits four clocks
    start(2'd0, 1'b1, 2, 8'd4);
    push($random(seed));
    push($random(seed));
    wr_valid = 1'b0;
    wait_for(0);
    compare("write retry", 32'h0, {31'h0, saw_stop});
    start(2'd3, 1'b1, 1, 8'd4);
    push($random(seed));
    wr_valid = 1'b0;
    wait_for(0);
    // first read phase left unanswered past its limit
    start(2'd1, 1'b0, 1, 8'd20);
    wait_for(0);
    compare("read retry", 32'h1, {31'h0, saw_stop});
    complete_run();
  end
endmodule
`default_nettype wire

// ### verilog/ptb_fifo.sv
// file: parameterised valid/ready fifo in flip-flops
`timescale 1ns/10ps
`default_nettype none
module ptb_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             nrst_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push = in_valid_i && in_ready_o;
  wire              pop  = out_valid_o && out_ready_i;

  assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ### verilog/ptb_passthru.sv
// file: add-on side pass-through handshake, holding register and retry timer
`timescale 1ns/10ps
`default_nettype none
module ptb_passthru
  import ptb_pkg::*;
(
  // clock and reset (buffered pci clock)
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  // pci target side, decoded
  input  wire logic        pci_frame_hit_i,
  input  wire ptb_pkg::ptb_req_s pci_req_i,
  input  wire logic        pci_irdy_n_i,
  input  wire logic        pci_last_i,
  input  wire logic        pci_wr_valid_i,
  input  wire logic [31:0] pci_wr_data_i,
  output logic             pci_wr_ready_o,
  output logic             pci_trdy_n_o,
  output logic             pci_stop_n_o,
  output logic [31:0]      pci_rd_data_o,
  output logic             pci_busy_o,
  // region widths from base-address configuration
  input  wire logic [7:0]  region_width_i,
  // add-on register port
  input  wire logic        local_select_n_i,
  input  wire logic [6:2]  local_addr_i,
  input  wire logic        local_addr_bit1_i,
  input  wire logic [3:0]  local_byte_en_n_i,
  input  wire logic        local_wr_n_i,
  input  wire logic        local_rd_n_i,
  input  wire logic [31:0] local_dq_i,
  output logic [31:0]      local_dq_o,
  output logic             local_dq_oe_o,
  input  wire logic        address_strobe_n_i,
  input  wire logic        local_xfer_ready_n_i,
  // pass-through status
  output logic             passthru_attention_n_o,
  output logic             pci_burst_flag_n_o,
  output logic [3:0]       pending_byte_en_n_o,
  output logic [1:0]       region_index_o,
  output logic             access_is_write_o
);
  ////////////////////////////////////////////////////////////////////////////
  ptb_state_e  state_reg, state_next;
  ptb_req_s    req_reg;
  logic [31:0] passthru_data_hold_reg;
  logic [3:0]  pend_n_reg;
  logic [4:0]  timer_reg;
  logic        first_reg;
  logic [1:0]  wphase_reg;
  logic        atn_n_reg, burst_n_reg, trdy_n_reg, stop_n_reg, oe_reg;
  logic [31:0] dq_reg, rd_data_reg;
  logic        wload_reg;
  logic [4:0]  wcnt_reg;
  ptb_word_s   fifo_out;
  logic        fifo_out_valid;

  // lowest asserted enable picks the read steering
  function automatic logic [31:0] rd_steer(input logic [31:0] d, input logic [3:0] be_n);
    if (!be_n[0]) rd_steer = d;
    else if (!be_n[1]) rd_steer = {d[31:16], d[15:8], d[15:8]};
    else if (!be_n[2]) rd_steer = {d[31:16], d[31:16]};
    else rd_steer = {4{d[31:24]}};
  endfunction

  // write lanes depend on the region width
  function automatic logic [31:0] wr_steer(input logic [31:0] q, input logic [1:0] w);
    case (w)
      PTB_W8:  wr_steer = {4{q[7:0]}};
      PTB_W16: wr_steer = {2{q[15:0]}};
      default: wr_steer = q;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  wire [1:0]  rwidth   = region_width_i[2*req_reg.region_index +: 2];
  wire        active   = (state_reg == PTB_ACTIVE) || (state_reg == PTB_RETRY);
  wire        sel_data = !local_select_n_i && ({local_addr_i, 2'b00} == PTB_OFS_DATA_HOLD);
  wire        sel_addr = !local_select_n_i && ({local_addr_i, 2'b00} == PTB_OFS_ADDR_HOLD);
  wire        atn      = !atn_n_reg;
  // in 16-bit mode address bit 1 picks the upper halfword's enables
  wire [3:0]  be16_n   = local_addr_bit1_i ? {local_byte_en_n_i[1:0], 2'b11}
                                           : {2'b11, local_byte_en_n_i[1:0]};
  wire [3:0]  eff_be_n = (rwidth == PTB_W16) ? be16_n : local_byte_en_n_i;
  // byte lanes written only where pending and add-on both assert
  wire [3:0]  wr_lane  = ~pend_n_reg & ~eff_be_n;
  wire        do_wr    = atn && sel_data && !local_wr_n_i && !req_reg.access_is_write;
  wire        do_rd    = atn && sel_data && !local_rd_n_i && req_reg.access_is_write;
  // completion only counts while attention is up; late ready is ignored
  wire        phase_done = atn && !local_xfer_ready_n_i;
  wire        timeout  = active && (timer_reg == 5'h01) && !phase_done && atn;
  // the first two write phases are always accepted
  wire        retry_ok = !(req_reg.access_is_write && wphase_reg < 2'd2);
  wire        fifo_in_ready;
  wire        fifo_pop = phase_done && req_reg.access_is_write;
  // only words offered while ready is high enter the buffer
  wire        fifo_push = pci_wr_valid_i && pci_wr_ready_o && fifo_in_ready;
  // a word beyond the one being drained, counting one arriving now
  wire        more_wr  = fifo_pop ? (wcnt_reg > 5'd1 || fifo_push) : fifo_out_valid;
  wire [31:0] steered  = wr_steer(local_dq_i, rwidth);
  // word as it stands after this edge's add-on write, so pci gets the byte just written
  wire [31:0] wr_mask  = {{8{do_wr && wr_lane[3]}}, {8{do_wr && wr_lane[2]}},
                          {8{do_wr && wr_lane[1]}}, {8{do_wr && wr_lane[0]}}};
  wire [31:0] merged   = (steered & wr_mask) | (passthru_data_hold_reg & ~wr_mask);
  wire [31:0] addr_rd  = (rwidth == PTB_W16) ?
                         (local_addr_bit1_i ? {16'h0000, req_reg.addr[31:16]}
                                            : {16'h0000, req_reg.addr[15:0]}) : req_reg.addr;

  ////////////////////////////////////////////////////////////////////////////
  ptb_fifo #(.WIDTH(PTB_FIFO_WIDTH), .DEPTH(PTB_FIFO_DEPTH)) u_wbuf (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({pci_req_i.byte_en_n, pci_wr_data_i}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // words held in the write buffers
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      wcnt_reg <= 5'h00;
    end else begin
      wcnt_reg <= wcnt_reg + 5'(fifo_push) - 5'(fifo_pop && fifo_out_valid);
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PTB_IDLE:   if (pci_frame_hit_i) state_next = PTB_ACTIVE;
      PTB_ACTIVE: if (timeout && retry_ok) state_next = PTB_RETRY;
                  else if (phase_done && pci_last_i && !more_wr) state_next = PTB_CLOSE;
      // one more phase with buffers drained
      PTB_RETRY:  if (phase_done && !more_wr) state_next = PTB_CLOSE;
      // one idle clock before new access
      PTB_CLOSE:  state_next = PTB_IDLE;
      default:    state_next = PTB_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_reg <= PTB_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // status latched at frame, held to end
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      req_reg <= '0;
    end else if (state_reg == PTB_IDLE && pci_frame_hit_i) begin
      req_reg <= pci_req_i;
    end
  end

  // attention follows irdy on reads only; ends with burst
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      atn_n_reg   <= 1'b1;
      burst_n_reg <= 1'b1;
    end else begin
      atn_n_reg   <= !(state_next == PTB_ACTIVE || state_next == PTB_RETRY) ||
                     (pci_irdy_n_i && !req_reg.access_is_write && state_reg != PTB_IDLE);
      burst_n_reg <= !(state_next == PTB_ACTIVE && !pci_last_i);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      timer_reg  <= '0;
      first_reg  <= 1'b1;
      wphase_reg <= '0;
    end else if (state_reg == PTB_IDLE) begin
      timer_reg  <= PTB_FIRST_LIMIT;
      first_reg  <= 1'b1;
      wphase_reg <= '0;
    end else if (phase_done) begin
      timer_reg  <= PTB_LATER_LIMIT;
      first_reg  <= 1'b0;
      wphase_reg <= (wphase_reg == 2'd3) ? wphase_reg : wphase_reg + 2'd1;
    end else if (atn && timer_reg != 5'h00) begin
      timer_reg <= timer_reg - 5'h01;
    end
  end

  // holding register writes; load from buffer
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      passthru_data_hold_reg <= PTB_DATA_RESET;
      pend_n_reg             <= 4'hF;
      wload_reg              <= 1'b0;
    end else if (state_reg == PTB_IDLE && pci_frame_hit_i) begin
      pend_n_reg <= pci_req_i.byte_en_n;
      wload_reg  <= 1'b0;
    end else if (req_reg.access_is_write && active && (!wload_reg || fifo_pop) && more_wr) begin
      passthru_data_hold_reg <= fifo_pop ? passthru_data_hold_reg : fifo_out.data;
      pend_n_reg             <= fifo_pop ? pend_n_reg : fifo_out.byte_en_n;
      wload_reg              <= !fifo_pop;
    end else begin
      if (fifo_pop) wload_reg <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        if (do_wr && wr_lane[i]) passthru_data_hold_reg[8*i +: 8] <= steered[8*i +: 8];
        if (do_rd && !eff_be_n[i]) pend_n_reg[i] <= 1'b1;
        if (do_wr && wr_lane[i]) pend_n_reg[i] <= 1'b1;
      end
      if (phase_done && !req_reg.access_is_write) pend_n_reg <= req_reg.byte_en_n;
    end
  end

  // trdy one clock after ready outside retry; stop on timeout
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      trdy_n_reg  <= 1'b1;
      stop_n_reg  <= 1'b1;
      rd_data_reg <= '0;
    end else begin
      trdy_n_reg  <= !(phase_done && state_reg != PTB_RETRY);
      stop_n_reg  <= !(state_next == PTB_RETRY);
      if (phase_done) rd_data_reg <= merged;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      dq_reg <= '0;
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= !local_rd_n_i && (sel_data || sel_addr || !address_strobe_n_i);
      if (!address_strobe_n_i || sel_addr) dq_reg <= addr_rd;
      else dq_reg <= rd_steer(passthru_data_hold_reg, eff_be_n);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      pci_wr_ready_o <= 1'b0;
      pci_busy_o     <= 1'b0;
    end else begin
      // write buffers; refuse new access while not idle
      pci_wr_ready_o <= fifo_in_ready && state_reg == PTB_ACTIVE;
      pci_busy_o     <= state_next != PTB_IDLE || fifo_out_valid;
    end
  end

  assign pci_trdy_n_o           = trdy_n_reg;
  assign pci_stop_n_o           = stop_n_reg;
  assign pci_rd_data_o          = rd_data_reg;
  assign local_dq_o             = dq_reg;
  assign local_dq_oe_o          = oe_reg;
  assign passthru_attention_n_o = atn_n_reg;
  assign pci_burst_flag_n_o     = burst_n_reg;
  assign pending_byte_en_n_o    = pend_n_reg;
  assign region_index_o         = req_reg.region_index;
  assign access_is_write_o      = req_reg.access_is_write;
endmodule
`default_nettype wire

// ### verilog/ptb_pkg.sv
// package: constants and carrier types for the pass-through add-on handshake block
package ptb_pkg;
  localparam logic [6:0] PTB_OFS_DATA_HOLD   = 7'h2C;
  localparam logic [6:0] PTB_OFS_ADDR_HOLD   = 7'h1C;
  localparam int         PTB_CLK_NS          = 10;
  // first phase: transfer-ready by the 15th edge after attention
  localparam int         PTB_FIRST_EDGES     = 15;
  // later phases: transfer-ready by the 8th edge after the previous phase
  localparam int         PTB_LATER_EDGES     = 8;
  localparam logic [4:0] PTB_FIRST_LIMIT     = 5'(PTB_FIRST_EDGES);
  localparam logic [4:0] PTB_LATER_LIMIT     = 5'(PTB_LATER_EDGES);
  localparam logic [31:0] PTB_DATA_RESET     = 32'h0000_0000;
  localparam int         PTB_FIFO_DEPTH      = 16;
  localparam int         PTB_FIFO_WIDTH      = 36;
  // region width codes as loaded at initialization
  localparam logic [1:0] PTB_W_OFF           = 2'h0;
  localparam logic [1:0] PTB_W8              = 2'h1;
  localparam logic [1:0] PTB_W16             = 2'h2;
  localparam logic [1:0] PTB_W32             = 2'h3;

  // one pci-side access request
  typedef struct packed {
    logic [1:0]  region_index;
    logic        access_is_write;
    logic [3:0]  byte_en_n;
    logic [31:0] addr;
  } ptb_req_s;

  // one buffered pci write word
  typedef struct packed {
    logic [3:0]  byte_en_n;
    logic [31:0] data;
  } ptb_word_s;

  typedef enum logic [2:0] {PTB_IDLE, PTB_ACTIVE, PTB_RETRY, PTB_CLOSE} ptb_state_e;
endpackage
